// ### hw/pscg_defines.svh
// Register map, field positions and reset values of the system clock generator.
// Assumes inclusion by bare name from the package only; the clock generator module uses its macros without including it.
`ifndef PSCG_DEFINES_SVH
`define PSCG_DEFINES_SVH

`define PSCG_ADDR_CFG1       16'h1C1E
`define PSCG_ADDR_CFG2       16'h1C1F
`define PSCG_ADDR_MULT       16'h1C20
`define PSCG_ADDR_REFDIV     16'h1C21
`define PSCG_ADDR_SETUP      16'h1C22
`define PSCG_ADDR_OUTDIV     16'h1C23

`define PSCG_CFG2_SEL_BIT    0
`define PSCG_CFG2_STRAP_BIT  3
`define PSCG_MULT_EN_BIT     15
`define PSCG_MULT_RSV_HI     14
`define PSCG_MULT_RSV_LO     13
`define PSCG_MULT_PWRDN_BIT  12
`define PSCG_REFDIV_BYP_BIT  15
`define PSCG_OUTDIV_EN_BIT   9
`define PSCG_RATIO_HI        11
`define PSCG_POST_DIVIDE_RATIO_HI      7

`define PSCG_MULT_RESET      16'h1000
`define PSCG_SETUP_RESET     16'h0806
`define PSCG_ZERO16          16'h0000
`define PSCG_REF_OFFSET      13'h0004
`define PSCG_MULT_OFFSET     13'h0004
`define PSCG_POST_OFFSET     13'h0001
`define PSCG_LOCK_TIME_MS    4

`endif

// ### hw/pscg_pkg.sv
// Types shared by the system clock generator modules.
// Assumes nothing beyond the defines header.
package pscg_pkg;
  `include "pscg_defines.svh"

  typedef enum logic [2:0] {
    PSCG_SRC_BYPASS = 3'b001,
    PSCG_SRC_GAP    = 3'b010,
    PSCG_SRC_PLL    = 3'b100
  } pscg_src_state_t;
endpackage : pscg_pkg

// ### hw/pscg_divider.sv
// Level-sampled clock divider: divides a sampled clock level by a programmable value.
// Assumes the input level is synchronous to sys_clk_i and much slower than it.
module pscg_divider
  import pscg_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  // Divider
  input  wire logic        clk_lvl_i,
  input  wire logic [12:0] divide_i,
  output logic             clk_lvl_o
);
  logic        prev_q;
  logic [12:0] cnt_q;
  logic        rise;

  assign rise = clk_lvl_i & ~prev_q;

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      prev_q <= 1'b0;
    else
      prev_q <= clk_lvl_i;
  end

  // A ratio change takes effect at the next rising level, so a running count can be cut short or stretched.
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_q     <= 13'h0000;
      clk_lvl_o <= 1'b0;
    end
    else if (divide_i == 13'h0001)
    begin
      // Divide by one passes the level through; the wrap test alone would hold it high.
      clk_lvl_o <= clk_lvl_i;
    end
    else if (rise)
    begin
      if (cnt_q >= divide_i - 13'h0001)
        cnt_q <= 13'h0000;
      else
        cnt_q <= cnt_q + 13'h0001;
      clk_lvl_o <= (cnt_q >= divide_i - 13'h0001) || ((cnt_q + 13'h0001) < (divide_i >> 1));
    end
  end
endmodule : pscg_divider

// ### hw/pscg_clock_gen.sv
// System clock generator control: registers, reference and output dividers and
// the glitch-free switch between bypass and PLL sources.
// Assumes the CPU I/O port and all clock levels are synchronous to sys_clk_i.
//
// Function
// - No lock status exists; lock is only assumed after a fixed bypass wait.
// - Source switching in either direction produces no glitch or short period.
// - Reference divider bypass chooses direct or divided reference as PLL input.
// - Post-divider enable chooses divided or undivided PLL output.
// - PLL multiplication factor equals the feedback field plus 4.
// - Registers sit in CPU I/O space at 16-bit word addresses.
// - Source select resets to 0, so the system clock starts in bypass.
// - Power-down bit powers the PLL down when 1 and resets to 1.
// - The reference divider divides by the programmed ratio plus 4.
module pscg_clock_gen
  import pscg_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  // CPU I/O port
  input  wire logic [15:0] io_addr_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic [15:0] io_wdata_i,
  output logic      [15:0] io_rdata_o,
  // Clock sources and strap
  input  wire logic        external_input_clock_i,
  input  wire logic        rtc_clock_i,
  input  wire logic        clock_strap_i,
  input  wire logic        pll_output_clock_i,
  // PLL control
  output logic             pll_power_down_o,
  output logic             pll_enable_bit15_o,
  output logic      [12:0] pll_multiplier_o,
  output logic      [15:0] pll_setup_o,
  output logic             pll_reference_input_o,
  // System clock
  output logic             core_system_clock_o,
  output logic             pll_mode_active_o
);
  logic [1:0]      rst_sync_q;
  logic            rst_b;
  logic            sel_q;
  logic            strap_q;
  logic            strap_taken_q;
  logic [15:0]     mult_q;
  logic            ref_byp_q;
  logic [11:0]     ref_ratio_q;
  logic [15:0]     setup_q;
  logic            post_en_q;
  logic [7:0]      post_ratio_q;
  logic            ref_div_lvl;
  logic            post_div_lvl;
  logic            bypass_src;
  logic            pll_gated;
  logic            pll_src;
  pscg_src_state_t state_q;

  assign rst_b = rst_sync_q[1];

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  // The strap is caught once after reset release and then held.
  always_ff @(posedge sys_clk_i or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strap_q       <= 1'b0;
      strap_taken_q <= 1'b0;
    end
    else if (!strap_taken_q)
    begin
      strap_q       <= clock_strap_i;
      strap_taken_q <= 1'b1;
    end
  end

  // Register writes; addresses outside the map are ignored.
  always_ff @(posedge sys_clk_i or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sel_q        <= 1'b0;
      mult_q       <= `PSCG_MULT_RESET;
      ref_byp_q    <= 1'b0;
      ref_ratio_q  <= 12'h000;
      setup_q      <= `PSCG_SETUP_RESET;
      post_en_q    <= 1'b0;
      post_ratio_q <= 8'h00;
    end
    else if (io_wr_i)
    begin
      case (io_addr_i)
        `PSCG_ADDR_CFG2:   sel_q <= io_wdata_i[`PSCG_CFG2_SEL_BIT];
        `PSCG_ADDR_MULT:   mult_q <= io_wdata_i;
        `PSCG_ADDR_REFDIV:
        begin
          ref_byp_q   <= io_wdata_i[`PSCG_REFDIV_BYP_BIT];
          ref_ratio_q <= io_wdata_i[`PSCG_RATIO_HI:0];
        end
        `PSCG_ADDR_SETUP:  setup_q <= io_wdata_i;
        `PSCG_ADDR_OUTDIV:
        begin
          post_en_q    <= io_wdata_i[`PSCG_OUTDIV_EN_BIT];
          post_ratio_q <= io_wdata_i[`PSCG_POST_DIVIDE_RATIO_HI:0];
        end
        default:           sel_q <= sel_q;
      endcase
    end
  end

  // Registered read data; unmapped addresses and the first config register read zero.
  // No lock flag exists anywhere in the map.
  always_ff @(posedge sys_clk_i or negedge rst_b)
  begin
    if (!rst_b)
      io_rdata_o <= `PSCG_ZERO16;
    else if (io_rd_i)
    begin
      io_rdata_o <= `PSCG_ZERO16;
      case (io_addr_i)
        `PSCG_ADDR_CFG2:
        begin
          io_rdata_o[`PSCG_CFG2_SEL_BIT]   <= sel_q;
          io_rdata_o[`PSCG_CFG2_STRAP_BIT] <= strap_q;
        end
        `PSCG_ADDR_MULT:   io_rdata_o <= mult_q;
        `PSCG_ADDR_REFDIV:
        begin
          io_rdata_o[`PSCG_REFDIV_BYP_BIT] <= ref_byp_q;
          io_rdata_o[`PSCG_RATIO_HI:0]     <= ref_ratio_q;
        end
        `PSCG_ADDR_SETUP:  io_rdata_o <= setup_q;
        `PSCG_ADDR_OUTDIV:
        begin
          io_rdata_o[`PSCG_OUTDIV_EN_BIT]  <= post_en_q;
          io_rdata_o[`PSCG_POST_DIVIDE_RATIO_HI:0]   <= post_ratio_q;
        end
        default:           io_rdata_o <= `PSCG_ZERO16;
      endcase
    end
  end

  assign bypass_src = strap_q ? external_input_clock_i : rtc_clock_i;
  // A powered-down PLL is treated as a silent source.
  assign pll_gated  = pll_output_clock_i & ~mult_q[`PSCG_MULT_PWRDN_BIT];

  pscg_divider u_ref_div (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b),
    .clk_lvl_i (bypass_src),
    .divide_i  ({1'b0, ref_ratio_q} + `PSCG_REF_OFFSET),
    .clk_lvl_o (ref_div_lvl)
  );

  pscg_divider u_post_div (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b),
    .clk_lvl_i (pll_gated),
    .divide_i  ({5'b0_0000, post_ratio_q} + `PSCG_POST_OFFSET),
    .clk_lvl_o (post_div_lvl)
  );

  assign pll_src = post_en_q ? post_div_lvl : pll_gated;

  // PLL control outputs.
  always_ff @(posedge sys_clk_i or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pll_power_down_o      <= 1'b1;
      pll_enable_bit15_o    <= 1'b0;
      pll_multiplier_o      <= `PSCG_MULT_OFFSET;
      pll_setup_o           <= `PSCG_SETUP_RESET;
      pll_reference_input_o <= 1'b0;
    end
    else
    begin
      pll_power_down_o      <= mult_q[`PSCG_MULT_PWRDN_BIT];
      pll_enable_bit15_o    <= mult_q[`PSCG_MULT_EN_BIT];
      pll_multiplier_o      <= {1'b0, mult_q[`PSCG_RATIO_HI:0]} + `PSCG_MULT_OFFSET;
      pll_setup_o           <= setup_q;
      pll_reference_input_o <= ref_byp_q ? bypass_src : ref_div_lvl;
    end
  end

  // Glitch-free switch: leave a source only while it is low, hold the output low,
  // and join the new source only while it is low, so no high phase is ever cut.
  always_ff @(posedge sys_clk_i or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q             <= PSCG_SRC_BYPASS;
      core_system_clock_o <= 1'b0;
      pll_mode_active_o   <= 1'b0;
    end
    else
    begin
      case (state_q)
        PSCG_SRC_BYPASS:
        begin
          // Held low until the strap is caught, so the wrong source never leaks out.
          core_system_clock_o <= bypass_src & strap_taken_q;
          if (sel_q && !bypass_src)
          begin
            state_q             <= PSCG_SRC_GAP;
            core_system_clock_o <= 1'b0;
          end
        end
        PSCG_SRC_PLL:
        begin
          core_system_clock_o <= pll_src;
          if (!sel_q && !pll_src)
          begin
            state_q             <= PSCG_SRC_GAP;
            core_system_clock_o <= 1'b0;
          end
        end
        PSCG_SRC_GAP:
        begin
          core_system_clock_o <= 1'b0;
          if (sel_q && !pll_src)
          begin
            state_q           <= PSCG_SRC_PLL;
            pll_mode_active_o <= 1'b1;
          end
          else if (!sel_q && !bypass_src)
          begin
            state_q           <= PSCG_SRC_BYPASS;
            pll_mode_active_o <= 1'b0;
          end
        end
        default:
        begin
          state_q             <= PSCG_SRC_BYPASS;
          core_system_clock_o <= 1'b0;
          pll_mode_active_o   <= 1'b0;
        end
      endcase
    end
  end
endmodule : pscg_clock_gen

// ### verification/pscg_clock_gen_properties.sv
// Concurrent checks on the ports of the system clock generator.
// Assumes the CPU port and all clock levels are synchronous to sys_clk_i.
module pscg_clock_gen_checker
  import pscg_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  // CPU I/O port
  input wire logic [15:0] io_addr_i,
  input wire logic        io_wr_i,
  input wire logic        io_rd_i,
  input wire logic [15:0] io_wdata_i,
  input wire logic [15:0] io_rdata_o,
  // Clock sources and strap
  input wire logic        external_input_clock_i,
  input wire logic        rtc_clock_i,
  input wire logic        clock_strap_i,
  // PLL control and system clock
  input wire logic        pll_power_down_o,
  input wire logic        pll_enable_bit15_o,
  input wire logic [12:0] pll_multiplier_o,
  input wire logic        core_system_clock_o,
  input wire logic        pll_mode_active_o
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  logic wr_mult;
  logic rd_void;
  assign wr_mult = io_wr_i && (io_addr_i == 16'h1C20);
  assign rd_void = io_rd_i && ((io_addr_i < 16'h1C1F) || (io_addr_i > 16'h1C23));

  // The control outputs are copied from the register one cycle after the write lands.
  property p_mult;
    wr_mult |=> ##1 pll_multiplier_o == {1'b0, $past(io_wdata_i[11:0], 2)} + 13'h0004;
  endproperty
  a_mult: assert property (p_mult) else $error("multiplier is not field plus four");
  property p_pwrdn; wr_mult |=> ##1 pll_power_down_o == $past(io_wdata_i[12], 2); endproperty
  a_pwrdn: assert property (p_pwrdn) else $error("power-down bit not taken");
  property p_en15; wr_mult |=> ##1 pll_enable_bit15_o == $past(io_wdata_i[15], 2); endproperty
  a_en15: assert property (p_en15) else $error("enable bit 15 not taken");
  property p_setrd;
    io_wr_i && io_addr_i == 16'h1C22 ##2 io_rd_i && io_addr_i == 16'h1C22
      |=> io_rdata_o == $past(io_wdata_i, 3);
  endproperty
  a_setrd: assert property (p_setrd) else $error("setup word read back wrong");
  property p_void; rd_void |=> io_rdata_o == 16'h0000; endproperty
  a_void: assert property (p_void) else $error("unmapped read not zero");
  property p_hold; !io_rd_i |=> $stable(io_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_swlow; $changed(pll_mode_active_o) |-> !core_system_clock_o; endproperty
  a_swlow: assert property (p_swlow) else $error("source switched while clock high");
  property p_byp;
    core_system_clock_o && !pll_mode_active_o
      |-> ($past(clock_strap_i) ? $past(external_input_clock_i) : $past(rtc_clock_i));
  endproperty
  a_byp: assert property (p_byp) else $error("bypass clock from wrong source");

  c_enter: cover property ($rose(pll_mode_active_o));
  c_leave: cover property ($fell(pll_mode_active_o));
  c_void: cover property (rd_void);
endmodule : pscg_clock_gen_checker

bind pscg_clock_gen pscg_clock_gen_checker pscg_clock_gen_checker_i (.*);

// ### verification/pscg_clock_gen_test.sv
// Self-checking bench for the system clock generator.
// Assumes the checker is bound; clock sources are bench counters on sys_clk_i.
module pscg_clock_gen_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        io_wr_i = 1'b0;
  logic        io_rd_i = 1'b0;
  logic        clock_strap_i = 1'b1;
  logic        external_input_clock_i = 1'b0;
  logic        rtc_clock_i = 1'b0;
  logic        pll_output_clock_i = 1'b0;
  logic [15:0] io_addr_i = 16'h0000;
  logic [15:0] io_wdata_i = 16'h0000;
  logic [15:0] io_rdata_o, pll_setup_o, p;
  logic [12:0] pll_multiplier_o;
  logic        pll_power_down_o, pll_enable_bit15_o, pll_reference_input_o;
  logic        core_system_clock_o, pll_mode_active_o;
  int          err_total = 0;
  int          checks = 0;
  int          cyc = 0;

  pscg_clock_gen pscg_clock_gen_i (.*);

  initial
  begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // Input pin period 4, real-time clock period 6, PLL output period 2 cycles.
  always @(negedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    pll_output_clock_i <= ~pll_output_clock_i;
    if (cyc % 2 == 1)
      external_input_clock_i <= ~external_input_clock_i;
    if (cyc % 3 == 2)
      rtc_clock_i <= ~rtc_clock_i;
  end

  task automatic complete_run;
    if (err_total == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge sys_clk_i);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1'b1;
    @(negedge sys_clk_i);
    io_wr_i = 1'b0;
  endtask : wr

  task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
    @(negedge sys_clk_i);
    io_addr_i = a;
    io_rd_i = 1'b1;
    @(negedge sys_clk_i);
    io_rd_i = 1'b0;
    chk(io_rdata_o, exp);
  endtask : rdc

  // Period in cycles of the reference input or the core clock, after one settling edge.
  task automatic per(input bit s);
    logic prv;
    logic cur;
    int   e;
    prv = 1'b1;
    e = 0;
    p = 16'h0000;
    for (int n = 0; n < 400 && e < 3; n++)
    begin
      @(negedge sys_clk_i);
      cur = s ? core_system_clock_o : pll_reference_input_o;
      if (cur && !prv)
        e++;
      if (e == 2)
        p++;
      prv = cur;
    end
  endtask : per

  task automatic wmode(input logic v);
    for (int n = 0; n < 40 && pll_mode_active_o !== v; n++)
      @(negedge sys_clk_i);
    chk({15'h0000, pll_mode_active_o}, {15'h0000, v});
  endtask : wmode

  task automatic do_reset(input logic s);
    rst_b_i = 1'b0;
    clock_strap_i = s;
    repeat (2) @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
  endtask : do_reset

  task automatic enter_pll;
    repeat (40000) @(negedge sys_clk_i);
    wr(16'h1C1F, 16'h0001);
    wmode(1'b1);
  endtask : enter_pll

  task automatic t_reset;
    rdc(16'h1C20, 16'h1000);
    rdc(16'h1C22, 16'h0806);
    rdc(16'h1C1F, 16'h0008);
    wmode(1'b0);
    per(1'b1);
    chk(p, 16'h0004);
  endtask : t_reset

  task automatic t_regs;
    wr(16'h1C1E, 16'hFFFF);
    rdc(16'h1C1E, 16'h0000);
    rdc(16'h1C24, 16'h0000);
    wr(16'h1C21, 16'hFFFF);
    rdc(16'h1C21, 16'h8FFF);
    wr(16'h1C23, 16'hFFFF);
    rdc(16'h1C23, 16'h02FF);
    wr(16'h1C22, 16'h1234);
    rdc(16'h1C22, 16'h1234);
    chk(pll_setup_o, 16'h1234);
  endtask : t_regs

  task automatic t_refdiv;
    wr(16'h1C21, 16'h8000);
    per(1'b0);
    chk(p, 16'h0004);
    wr(16'h1C21, 16'h0001);
    per(1'b0);
    chk(p, 16'h0014);
  endtask : t_refdiv

  // Nothing else runs in the bench, so the quiet-peripheral advice holds throughout.
  task automatic t_pll;
    wr(16'h1C20, 16'h1000);
    wr(16'h1C23, 16'h0202);
    wr(16'h1C22, 16'h0806);
    wr(16'h1C20, 16'h8005);
    @(negedge sys_clk_i);
    chk({3'h0, pll_multiplier_o}, 16'h0009);
    chk({14'h0000, pll_power_down_o, pll_enable_bit15_o}, 16'h0001);
    enter_pll;
    per(1'b1);
    chk(p, 16'h0006);
    wr(16'h1C1F, 16'h0000);
    wmode(1'b0);
    per(1'b1);
    chk(p, 16'h0004);
    wr(16'h1C23, 16'h0000);
    enter_pll;
    per(1'b1);
    chk(p, 16'h0002);
  endtask : t_pll

  task automatic t_rtc;
    do_reset(1'b0);
    rdc(16'h1C1F, 16'h0000);
    per(1'b1);
    chk(p, 16'h0006);
    wr(16'h1C21, 16'h8000);
    per(1'b0);
    chk(p, 16'h0006);
  endtask : t_rtc

  // Two lock waits dominate the run; this leaves margin without passing the cycle budget.
  initial
  begin
    repeat (90000) @(posedge sys_clk_i);
    err_total++;
    complete_run;
  end

  initial
  begin
    do_reset(1'b1);
    t_reset;
    t_regs;
    t_refdiv;
    t_pll;
    t_rtc;
    complete_run;
  end
endmodule : pscg_clock_gen_test
